/* File: core/sr_ctrl.sv */
// controller end: apb registers drive entry, exit and mask writes
// assumes the link to one device on the same CLK
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "sr_consts.svh"
module sr_ctrl (
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output var  logic [31:0] PRDATA,
  output var  logic        PREADY,
  output var  logic        PSLVERR,
  sr_link_if.ctrl          LINK
);
  sr_pkg::host_state_t st_q;
  logic [7:0] cnt_q;
  logic       ref_done_q;
  logic       want_sr_q;
  logic [7:0] bank_q;
  logic [7:0] seg_q;
  logic [1:0] mrw_pend_q;
  // apb decode
  wire acc    = PSEL && PENABLE && !PREADY;
  wire wr     = PSEL && PENABLE && PREADY && PWRITE; // write lands with pready high
  wire hit_c  = PADDR == `REG_CTRL;
  wire hit_b  = PADDR == `REG_BANK_MASK;
  wire hit_s  = PADDR == `REG_SEG_MASK;
  wire hit_st = PADDR == `REG_STATUS;
  wire mapped = hit_c || hit_b || hit_s || hit_st;
  wire idle   = st_q == sr_pkg::HS_IDLE;
  wire [31:0] rd = hit_c ? {31'h0, want_sr_q} :
                   hit_b ? {24'h0, bank_q} :
                   hit_s ? {24'h0, seg_q} :
                   hit_st ? {26'h0, mrw_pend_q, ref_done_q, 3'(st_q)} : 32'h0000_0000;
  // apb slave answers one cycle into access phase
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end
    else
    begin
      PREADY  <= acc;
      PRDATA  <= acc ? rd : 32'h0000_0000;
      PSLVERR <= acc && !mapped;
    end
  end
  // software registers
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      want_sr_q  <= 1'b0;
      bank_q     <= `SR_MASK_RESET;
      seg_q      <= `SR_MASK_RESET;
      mrw_pend_q <= 2'b00;
    end
    else
    begin
      if (wr && hit_c)
        want_sr_q <= PWDATA[0];
      if (wr && hit_b)
        bank_q <= PWDATA[7:0];
      if (wr && hit_s)
        seg_q <= PWDATA[7:0];
      mrw_pend_q[0] <= (wr && hit_b) || (mrw_pend_q[0] && !(st_q == sr_pkg::HS_MRW && !cnt_q[0]));
      mrw_pend_q[1] <= (wr && hit_s) || (mrw_pend_q[1] && !(st_q == sr_pkg::HS_MRW && cnt_q[0]));
    end
  end
  // link sequencer
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      st_q <= sr_pkg::HS_IDLE;
      cnt_q <= 8'h00;
      ref_done_q <= 1'b1;
      LINK.cke <= 1'b1;
      LINK.cs_n <= 1'b1;
      LINK.cmd <= sr_pkg::CMD_NOP;
      LINK.ma <= 8'h00;
      LINK.op <= 8'h00;
      LINK.clk_run <= 1'b1;
    end
    else
    begin
      LINK.cs_n <= 1'b1;
      LINK.cmd  <= sr_pkg::CMD_NOP;
      cnt_q <= cnt_q + 8'h01;
      unique case (st_q)
        sr_pkg::HS_IDLE:
          if (mrw_pend_q != 2'b00)
          begin
            st_q <= sr_pkg::HS_MRW;
            cnt_q <= {7'h0, ~mrw_pend_q[0]};
          end
          else if (want_sr_q && !ref_done_q)
          begin
            st_q <= sr_pkg::HS_REFRESH;
            cnt_q <= 8'h00;
          end
          else if (want_sr_q)
          begin
            st_q <= sr_pkg::HS_PREA;
            LINK.cs_n <= 1'b0;
            LINK.cmd <= sr_pkg::CMD_PREA;
          end
        sr_pkg::HS_MRW:
        begin
          LINK.cs_n <= 1'b0;
          LINK.cmd <= sr_pkg::CMD_MRW;
          LINK.ma <= cnt_q[0] ? `SR_SEG_MASK_ADDR : `SR_BANK_MASK_ADDR;
          LINK.op <= cnt_q[0] ? seg_q : bank_q;
          st_q <= sr_pkg::HS_IDLE;
        end
        sr_pkg::HS_REFRESH:
        begin
          LINK.cs_n <= 1'b0;
          if (cnt_q == 8'h00)
            LINK.cmd <= sr_pkg::CMD_REF_PB; // advances the bank counter first
          else
          begin
            LINK.cmd <= sr_pkg::CMD_REF_AB;
            ref_done_q <= 1'b1;
            st_q <= sr_pkg::HS_IDLE;
          end
        end
        sr_pkg::HS_PREA:
        begin
          LINK.cke <= 1'b0;
          LINK.cs_n <= 1'b0;
          LINK.cmd <= sr_pkg::CMD_SREF;
          st_q <= sr_pkg::HS_ENTRY;
        end
        sr_pkg::HS_ENTRY:
        begin
          LINK.clk_run <= 1'b0;
          cnt_q <= 8'h00;
          ref_done_q <= 1'b0;
          st_q <= sr_pkg::HS_RESIDE;
        end
        sr_pkg::HS_RESIDE:
          if (!want_sr_q && cnt_q >= 8'(`SR_RESIDENCY_CYC))
          begin
            LINK.clk_run <= 1'b1;
            cnt_q <= 8'h00;
            st_q <= sr_pkg::HS_CLK_WAKE;
          end
          else if (cnt_q == 8'hFF)
            cnt_q <= cnt_q;
        sr_pkg::HS_CLK_WAKE:
          if (cnt_q == 8'(`SR_STABLE_CLKS - 1))
          begin
            LINK.cke <= 1'b1;
            cnt_q <= 8'h00;
            st_q <= sr_pkg::HS_EXIT;
          end
        sr_pkg::HS_EXIT:
          if (cnt_q == 8'(`SR_EXIT_CYC))
            st_q <= sr_pkg::HS_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: core/sr_consts.svh */
// constants for the self refresh and partial array retention link
// assumes inclusion by both ends, the checker and the bench; definitions only
`ifndef SR_CONSTS_SVH
`define SR_CONSTS_SVH
`define SR_BANK_MASK_ADDR   8'h10
`define SR_SEG_MASK_ADDR    8'h11
`define SR_MASK_RESET       8'h00
`define SR_CLK_NS           8
`define SR_RESIDENCY_NS     15
`define SR_RESIDENCY_CYC    ((`SR_RESIDENCY_NS + `SR_CLK_NS - 1) / `SR_CLK_NS)
`define SR_EXIT_NS          140
`define SR_EXIT_CYC         ((`SR_EXIT_NS + `SR_CLK_NS - 1) / `SR_CLK_NS)
`define SR_INT_REF_NS       64
`define SR_INT_REF_CYC      ((`SR_INT_REF_NS) / `SR_CLK_NS)
`define SR_STABLE_CLKS      2
`define SR_PB_PER_AB        8
`define REG_CTRL            8'h00
`define REG_STATUS          8'h04
`define REG_BANK_MASK       8'h08
`define REG_SEG_MASK        8'h0C
`define REG_DEV_STATE       8'h10
`endif

/* File: core/sr_pkg.sv */
// types for the self refresh link; only the command codes are used by both ends
// numeric values set here, none taken from sr_consts.svh
package sr_pkg;
  // command codes on ca[3:0] with cs_n low
  typedef enum logic [3:0] {
    CMD_NOP     = 4'h7,
    CMD_SREF    = 4'h4,
    CMD_REF_AB  = 4'hC,
    CMD_REF_PB  = 4'h8,
    CMD_MRW     = 4'h0,
    CMD_PREA    = 4'hB
  } cmd_t;
  typedef enum logic [1:0] {
    DS_ACTIVE,
    DS_SELF_REF,
    DS_EXIT
  } dev_state_t;
  typedef enum logic [2:0] {
    HS_IDLE,
    HS_PREA,
    HS_ENTRY,
    HS_RESIDE,
    HS_CLK_WAKE,
    HS_EXIT,
    HS_REFRESH,
    HS_MRW
  } host_state_t;
endpackage

/* File: core/sr_link_if.sv */
// link between memory controller and self refresh device
// assumes one shared clock; clk_run models external clock running
`timescale 1ns/1ps
`default_nettype none
interface sr_link_if;
  logic       cke;
  logic       cs_n;
  logic [3:0] cmd;
  logic [7:0] ma;
  logic [7:0] op;
  logic       clk_run;
  modport ctrl (output cke, output cs_n, output cmd, output ma, output op, output clk_run);
  modport dev  (input cke, input cs_n, input cmd, input ma, input op, input clk_run);
endinterface
`default_nettype wire

/* File: core/sr_device.sv */
// device end: self refresh entry, residency, exit and masked refresh
// assumes the link driven by a controller on the same CLK
`timescale 1ns/1ps
`default_nettype none
`include "sr_consts.svh"
module sr_device (
  input  wire logic     CLK,
  input  wire logic     RST,
  sr_link_if.dev        LINK,
  output var  logic [1:0] STATE,
  output var  logic [7:0] BANK_MASK,
  output var  logic [7:0] SEG_MASK,
  output var  logic     CLK_GATED,
  output var  logic     INT_REF_PULSE,
  output var  logic [63:0] REF_MAP,
  output var  logic [2:0] PB_COUNT,
  output var  logic [15:0] INT_REF_COUNT
);
  sr_pkg::dev_state_t state_q;
  logic [7:0]  bank_q;
  logic [7:0]  seg_q;
  logic [7:0]  tmr_q;
  logic [7:0]  xsr_q;
  logic [2:0]  pb_q;
  logic [15:0] nref_q;
  logic        cke_d1_q;
  logic        pulse_q;
  logic [63:0] map_q;
  // decode of registered commands
  wire sel       = !LINK.cs_n;
  wire in_active = state_q == sr_pkg::DS_ACTIVE;
  wire do_entry  = in_active && cke_d1_q && !LINK.cke && sel
                   && LINK.cmd == sr_pkg::CMD_SREF;
  wire do_mrw    = in_active && LINK.cke && sel && LINK.cmd == sr_pkg::CMD_MRW;
  wire do_all_bank_refresh  = in_active && LINK.cke && sel && LINK.cmd == sr_pkg::CMD_REF_AB;
  wire do_per_bank_refresh  = in_active && LINK.cke && sel && LINK.cmd == sr_pkg::CMD_REF_PB;
  wire in_sr     = state_q == sr_pkg::DS_SELF_REF;
  wire tmr_hit   = in_sr && tmr_q == 8'h00; // first refresh lands inside the residency
  wire do_exit   = in_sr && LINK.cke;
  // refreshed cells: bank unmasked and segment unmasked
  logic [63:0] map_d;
  genvar b;
  generate
    for (b = 0; b < 8; b = b + 1)
    begin : g_bank
      assign map_d[b*8 +: 8] = bank_q[b] ? 8'h00 : ~seg_q;
    end
  endgenerate
  // state machine
  always_ff @(posedge CLK)
  begin
    if (RST)
      state_q <= sr_pkg::DS_ACTIVE;
    else
    begin
      unique case (state_q)
        sr_pkg::DS_ACTIVE:   if (do_entry) state_q <= sr_pkg::DS_SELF_REF;
        sr_pkg::DS_SELF_REF: if (do_exit) state_q <= sr_pkg::DS_EXIT;
        sr_pkg::DS_EXIT:     if (xsr_q == 8'(`SR_EXIT_CYC - 1)) state_q <= sr_pkg::DS_ACTIVE;
      endcase
    end
  end
  // exit delay counter, starts at the edge after cke rose
  always_ff @(posedge CLK)
  begin
    if (RST || state_q != sr_pkg::DS_EXIT)
      xsr_q <= 8'h00;
    else
      xsr_q <= xsr_q + 8'h01;
  end
  // built-in refresh timer, fires at once on entry and then once per period
  always_ff @(posedge CLK)
  begin
    if (RST || !in_sr || tmr_q == 8'(`SR_INT_REF_CYC - 1))
      tmr_q <= 8'h00;
    else
      tmr_q <= tmr_q + 8'h01;
  end
  // internal refresh pulse and refreshed cell map
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      pulse_q <= 1'b0;
      map_q   <= 64'h0000_0000_0000_0000;
      nref_q  <= 16'h0000;
    end
    else
    begin
      pulse_q <= tmr_hit;
      map_q   <= tmr_hit ? map_d : 64'h0000_0000_0000_0000;
      if (do_entry)
        nref_q <= 16'h0000;
      else if (tmr_hit)
        nref_q <= nref_q + 16'h0001;
    end
  end
  // mask registers written by mode register write
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      bank_q <= `SR_MASK_RESET;
      seg_q  <= `SR_MASK_RESET;
    end
    else if (do_mrw && LINK.ma == `SR_BANK_MASK_ADDR)
      bank_q <= LINK.op;
    else if (do_mrw && LINK.ma == `SR_SEG_MASK_ADDR)
      seg_q <= LINK.op;
  end
  // per-bank refresh counter
  always_ff @(posedge CLK)
  begin
    if (RST || do_all_bank_refresh)
      pb_q <= 3'h0;
    else if (do_per_bank_refresh)
      pb_q <= pb_q + 3'h1;
  end
  always_ff @(posedge CLK)
  begin
    if (RST)
      cke_d1_q <= 1'b0;
    else
      cke_d1_q <= LINK.cke;
  end
  // registered outputs
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      STATE         <= 2'b00;
      BANK_MASK     <= 8'h00;
      SEG_MASK      <= 8'h00;
      CLK_GATED     <= 1'b0;
      INT_REF_PULSE <= 1'b0;
      REF_MAP       <= 64'h0000_0000_0000_0000;
      PB_COUNT      <= 3'h0;
      INT_REF_COUNT <= 16'h0000;
    end
    else
    begin
      STATE         <= state_q;
      BANK_MASK     <= bank_q;
      SEG_MASK      <= seg_q;
      CLK_GATED     <= in_sr;
      INT_REF_PULSE <= pulse_q;
      REF_MAP       <= map_q;
      PB_COUNT      <= pb_q;
      INT_REF_COUNT <= nref_q;
    end
  end
endmodule
`default_nettype wire

/* File: testbench/sr_link_props.sv */
// checker for the self refresh link, watches cke, cs_n, cmd and clk_run of the interface
// assumes instantiation beside the link in the bench top
`timescale 1ns/1ps
`default_nettype none
`include "sr_consts.svh"
module sr_link_props (
  input wire logic       CLK,
  input wire logic       RST,
  input wire logic       cke,
  input wire logic       cs_n,
  input wire logic [3:0] cmd,
  input wire logic       clk_run
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  logic [4:0] xcnt_q;
  logic       need_q;
  logic       prea_q;
  sequence entry_s;
    $fell(cke) ##0 (!cs_n && cmd == sr_pkg::CMD_SREF);
  endsequence
  sequence nop_s;
    cs_n || cmd == sr_pkg::CMD_NOP;
  endsequence
  // exit delay countdown, refresh owed since exit, precharge seen
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      xcnt_q <= 5'h0;
      need_q <= 1'b0;
      prea_q <= 1'b0;
    end
    else
    begin
      xcnt_q <= $rose(cke) ? 5'(`SR_EXIT_CYC - 1) : xcnt_q - 5'(xcnt_q != 5'h0);
      need_q <= $rose(cke) | (need_q & ~(!cs_n && cmd == sr_pkg::CMD_REF_AB));
      prea_q <= (!cs_n && cmd == sr_pkg::CMD_PREA) | (prea_q & ~$fell(cke));
    end
  end
  entry_cmd_a: assert property ($fell(cke) |-> !cs_n && cmd == sr_pkg::CMD_SREF)
    else $error("cke fell without entry command");
  nop_after_a: assert property (entry_s |=> nop_s)
    else $error("no nop after entry");
  cke_reside_a: assert property (entry_s |=> !cke [*2])
    else $error("residency cut short");
  clk_stop_a: assert property (!clk_run |-> !cke && !$past(cke))
    else $error("clock stopped outside self refresh");
  stable_clk_a: assert property ($rose(cke) |-> $past(clk_run) && $past(clk_run, 2))
    else $error("exit without two stable clocks");
  exit_nop_a: assert property (($rose(cke) || xcnt_q != 5'h0) |-> cke && (cs_n ||
    cmd == sr_pkg::CMD_NOP))
    else $error("command during exit delay");
  ref_between_a: assert property (entry_s |-> !need_q)
    else $error("no refresh between self refreshes");
  idle_entry_a: assert property (entry_s |-> prea_q)
    else $error("entry without precharge all");
endmodule
`default_nettype wire

/* File: testbench/sdram_self_refresh_partial_array_retention_test.sv */
// bench: controller and device joined by the link, driven over apb
// assumes the core files and the checker compiled first
`timescale 1ns/1ps
`default_nettype none
`include "sr_consts.svh"
module sdram_self_refresh_partial_array_retention_test;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [1:0]  state;
  logic [7:0]  bank_mask;
  logic [7:0]  seg_mask;
  logic        clk_gated;
  logic        ref_pulse;
  logic [63:0] ref_map;
  logic [2:0]  pb_count;
  logic [15:0] ref_count;
  int          fail_count = 0;
  int          n_tests = 0;
  int          cyc = 0;
  sr_link_if link ();
  sr_ctrl sr_ctrl_i (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .LINK(link.ctrl));
  sr_device sr_device_i (.CLK(clk), .RST(rst), .LINK(link.dev), .STATE(state),
    .BANK_MASK(bank_mask), .SEG_MASK(seg_mask), .CLK_GATED(clk_gated),
    .INT_REF_PULSE(ref_pulse), .REF_MAP(ref_map), .PB_COUNT(pb_count),
    .INT_REF_COUNT(ref_count));
  sr_link_props sr_link_props_i (.CLK(clk), .RST(rst), .cke(link.cke),
    .cs_n(link.cs_n), .cmd(link.cmd), .clk_run(link.clk_run));
  // clock and hang guard
  always #4 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      final_report();
    end
  end
  task automatic final_report();
    $display("tests %0d errors %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_st(input logic [1:0] s, output int n);
    n = 0;
    do @(negedge clk); while (state !== s && ++n < 400);
  endtask
  function automatic logic [63:0] map(input logic [7:0] b, input logic [7:0] s);
    for (int i = 0; i < 64; i++)
      map[i] = !b[i / 8] && !s[i % 8];
  endfunction
  // masks, entry, residency refresh pattern, exit delay
  task automatic sref(input logic [7:0] b, input logic [7:0] s);
    logic [31:0] q;
    logic        e;
    int          n;
    apb(1'b1, `REG_BANK_MASK, {24'h00_0000, b}, q, e);
    apb(1'b1, `REG_SEG_MASK, {24'h00_0000, s}, q, e);
    apb(1'b0, 8'h20, 32'h0000_0000, q, e);
    check({q, 31'h0, e}, {32'h0000_0000, 32'h0000_0001});
    repeat (10)
    begin
      apb(1'b0, `REG_STATUS, 32'h0000_0000, q, e);
      if (q[5:4] === 2'b00)
        break;
    end
    @(negedge clk);
    check({bank_mask, seg_mask}, {b, s});
    apb(1'b0, `REG_SEG_MASK, 32'h0000_0000, q, e);
    check(q, {24'h00_0000, s});
    apb(1'b1, `REG_CTRL, 32'h0000_0001, q, e);
    wait_st(2'd1, n);
    check(clk_gated, 1'b1);
    n = 0;
    do @(negedge clk); while (ref_pulse !== 1'b1 && ++n < 100);
    check(n <= `SR_RESIDENCY_CYC - 1, 1'b1);
    check(ref_map, map(b, s));
    check(pb_count, 3'h0);
    apb(1'b1, `REG_CTRL, 32'h0000_0000, q, e);
    check(ref_count != 16'h0, 1'b1);
    wait_st(2'd2, n);
    wait_st(2'd0, n);
    check(n, `SR_EXIT_CYC - 1);
  endtask
  // reset, then the mask cases
  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    sref(8'h82, 8'h84);
    sref(8'h00, 8'h00);
    sref(8'hFF, 8'h01);
    final_report();
  end
endmodule
`default_nettype wire
